// ### hw/bfc_map.svh
// Register offsets, field positions, reset values and scaling constants for feedback config
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH
`define BFC_OFF_CALIB_BEMF 8'h19
`define BFC_OFF_FB_CTRL 8'h1A
`define BFC_RST_CALIB_BEMF 8'h6F
`define BFC_RST_FB_CTRL 8'h36
`define BFC_ACT_BIT 7
`define BFC_BRAKE_HI 6
`define BFC_BRAKE_LO 4
`define BFC_LOOP_HI 3
`define BFC_LOOP_LO 2
`define BFC_AMP_HI 1
`define BFC_AMP_LO 0
`define BFC_BRAKE_OFF 3'h7
`define BFC_FULL_CODE 16'h00FF
`define BFC_VREF_MV 16'h04C4
`define BFC_RST_RDATA 8'h00
`define BFC_RDATA_NONE 8'h00
`define BFC_RST_BRAKE_MULT 5'h04
`define BFC_RST_BRAKE_EN 1'b1
`define BFC_RST_BEMF_MV 16'h0000
`define BFC_RST_FB_GAIN 16'h0000
`define BFC_MULT_1X 5'h01
`define BFC_MULT_2X 5'h02
`define BFC_MULT_3X 5'h03
`define BFC_MULT_4X 5'h04
`define BFC_MULT_6X 5'h06
`define BFC_MULT_8X 5'h08
`define BFC_MULT_16X 5'h10
`define BFC_MULT_NONE 5'h00
`define BFC_AMP_MILLI_0 16'h00FF
`define BFC_AMP_MILLI_1 16'h0314
`define BFC_AMP_MILLI_2 16'h0555
`define BFC_AMP_MILLI_3 16'h0BB8
`define BFC_MILLI 32'h0000_03E8
`define BFC_GAIN_NUM 32'h0000_FFFF
`define BFC_GAIN_MAX 16'hFFFF
`define BFC_CODE_ZERO 8'h00
`define BFC_DIV_ONE 32'h0000_0001
`endif

// ### hw/bfc_pkg.sv
// Types shared by the feedback configuration block
package bfc_pkg;
	typedef logic [7:0] bfc_byte_t;
	typedef enum logic {
		BFC_ROTATING_MASS_MODE = 1'b0,
		BFC_LINEAR_RESONANT_MODE = 1'b1
	} bfc_act_e;
endpackage : bfc_pkg

// ### hw/bfc_regs.sv
// Back-EMF calibration result and feedback control register bank
// Notes on behaviour
// - Calibration back-EMF byte, writable, reset 0x6F
// - Byte holds back-EMF at rated drive
// - Feedback gain derived from calibration byte
// - Level = code/255 times 1.22V over gain
// - Bit 7 selects rotating or linear mode
// - Bits 6-4 brake ratio, reset 3
// - Two-bit amplifier gain, default 2
`timescale 1ns/1ps
`include "bfc_map.svh"
module bfc_regs (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire bfc_pkg::bfc_byte_t wdata_i,
	input wire logic cal_wr_i,
	input wire bfc_pkg::bfc_byte_t cal_level_i,
	input wire logic [1:0] cal_amp_gain_i,
	output bfc_pkg::bfc_byte_t rdata_o,
	output logic actuator_type_select_o,
	output logic [4:0] brake_gain_mult_o,
	output logic brake_enable_o,
	output logic [1:0] backemf_amp_gain_o,
	output logic [15:0] calib_backemf_mv_o,
	output logic [15:0] fb_gain_o
);
	import bfc_pkg::*;
	bfc_byte_t calib_backemf_level;
	bfc_byte_t next_calib_backemf_level;
	bfc_byte_t fb_ctrl;
	bfc_byte_t next_fb_ctrl;
	bfc_byte_t rdata;
	bfc_byte_t next_rdata;
	logic [4:0] brake_mult;
	logic [4:0] next_brake_mult;
	logic brake_en;
	logic next_brake_en;
	logic [15:0] bemf_mv;
	logic [15:0] next_bemf_mv;
	logic [15:0] fb_gain;
	logic [15:0] next_fb_gain;
	logic hit_calib;
	logic hit_ctrl;
	logic host_wr_calib;
	logic host_wr_ctrl;
	logic [2:0] brake_code;
	logic [1:0] amp_code;
	logic [15:0] amp_milli;
	logic [31:0] mv_num;
	logic [31:0] mv_den;
	logic [31:0] mv_scaled;
	logic [31:0] gain_div;
	logic [31:0] gain_quot;

	// offset decode, one hit at most
	always_comb begin
		hit_calib = 1'b0;
		hit_ctrl = 1'b0;
		if (addr_i == `BFC_OFF_CALIB_BEMF) begin
			hit_calib = 1'b1;
		end else if (addr_i == `BFC_OFF_FB_CTRL) begin
			hit_ctrl = 1'b1;
		end
		host_wr_calib = wr_en_i && hit_calib;
		host_wr_ctrl = wr_en_i && hit_ctrl;
	end

	always_comb begin
		next_calib_backemf_level = calib_backemf_level;
		next_fb_ctrl = fb_ctrl;
		// host write of the calibration byte
		if (host_wr_calib) begin
			next_calib_backemf_level = wdata_i;
		end
		// control byte, loop gain bits stored only
		if (host_wr_ctrl) begin
			next_fb_ctrl = wdata_i;
		end
		// engine result wins over a same-cycle host write
		if (cal_wr_i) begin
			next_calib_backemf_level = cal_level_i;
			next_fb_ctrl[`BFC_AMP_HI:`BFC_AMP_LO] = cal_amp_gain_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			calib_backemf_level <= `BFC_RST_CALIB_BEMF;
			fb_ctrl <= `BFC_RST_FB_CTRL;
		end else begin
			calib_backemf_level <= next_calib_backemf_level;
			fb_ctrl <= next_fb_ctrl;
		end
	end

	// read return; a same-cycle write is seen only by the next read
	always_comb begin
		next_rdata = rdata;
		if (rd_en_i) begin
			if (hit_calib) begin
				next_rdata = calib_backemf_level;
			end else if (hit_ctrl) begin
				next_rdata = fb_ctrl;
			end else begin
				next_rdata = `BFC_RDATA_NONE;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rdata <= `BFC_RST_RDATA;
		end else begin
			rdata <= next_rdata;
		end
	end

	always_comb begin
		brake_code = fb_ctrl[`BFC_BRAKE_HI:`BFC_BRAKE_LO];
		next_brake_en = (brake_code != `BFC_BRAKE_OFF);
		next_brake_mult = `BFC_MULT_NONE;
		case (brake_code)
			3'h0: begin
				next_brake_mult = `BFC_MULT_1X;
			end
			3'h1: begin
				next_brake_mult = `BFC_MULT_2X;
			end
			3'h2: begin
				next_brake_mult = `BFC_MULT_3X;
			end
			3'h3: begin
				next_brake_mult = `BFC_MULT_4X;
			end
			3'h4: begin
				next_brake_mult = `BFC_MULT_6X;
			end
			3'h5: begin
				next_brake_mult = `BFC_MULT_8X;
			end
			3'h6: begin
				next_brake_mult = `BFC_MULT_16X;
			end
			default: begin
				// code 7 disables braking, multiplier reads zero
				next_brake_mult = `BFC_MULT_NONE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			brake_mult <= `BFC_RST_BRAKE_MULT;
			brake_en <= `BFC_RST_BRAKE_EN;
		end else begin
			brake_mult <= next_brake_mult;
			brake_en <= next_brake_en;
		end
	end

	// amplifier gain in thousandths; rotating-mass table serves both modes
	always_comb begin
		amp_code = fb_ctrl[`BFC_AMP_HI:`BFC_AMP_LO];
		case (amp_code)
			2'h0: begin
				amp_milli = `BFC_AMP_MILLI_0;
			end
			2'h1: begin
				amp_milli = `BFC_AMP_MILLI_1;
			end
			2'h2: begin
				amp_milli = `BFC_AMP_MILLI_2;
			end
			default: begin
				amp_milli = `BFC_AMP_MILLI_3;
			end
		endcase
	end

	// level in mV = code/255 times 1220 mV over gain, truncated
	always_comb begin
		mv_num = 32'(calib_backemf_level) * 32'(`BFC_VREF_MV) * `BFC_MILLI;
		mv_den = 32'(`BFC_FULL_CODE) * 32'(amp_milli);
		mv_scaled = mv_num / mv_den;
		next_bemf_mv = mv_scaled[15:0];
		// Divisor held at one for code zero so the divider never sees zero
		gain_div = `BFC_DIV_ONE;
		if (calib_backemf_level != `BFC_CODE_ZERO) begin
			gain_div = 32'(calib_backemf_level);
		end
		// higher back-EMF needs less loop gain; coarse reciprocal keeps it cheap
		gain_quot = `BFC_GAIN_NUM / gain_div;
		if (calib_backemf_level == `BFC_CODE_ZERO) begin
			next_fb_gain = `BFC_GAIN_MAX;
		end else begin
			next_fb_gain = gain_quot[15:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			bemf_mv <= `BFC_RST_BEMF_MV;
			fb_gain <= `BFC_RST_FB_GAIN;
		end else begin
			bemf_mv <= next_bemf_mv;
			fb_gain <= next_fb_gain;
		end
	end

	// type and amp gain outputs straight from the control byte flops; brake outputs from their own decode flops, a cycle later
	assign rdata_o = rdata;
	assign actuator_type_select_o = fb_ctrl[`BFC_ACT_BIT];
	assign backemf_amp_gain_o = fb_ctrl[`BFC_AMP_HI:`BFC_AMP_LO];
	assign brake_gain_mult_o = brake_mult;
	assign brake_enable_o = brake_en;
	assign calib_backemf_mv_o = bemf_mv;
	assign fb_gain_o = fb_gain;
endmodule : bfc_regs

// ### verification/bfc_host.sv
// Host model: one register strobe per call, then an idle cycle
`timescale 1ns/1ps
module bfc_host (
	input wire logic clk_i,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] data_o = 8'h00
);
	// callers program mode and ratio first
	task automatic x(input logic w, input logic [7:0] ad, dt);
		{wr_o, rd_o, addr_o, data_o} = {w, !w, ad, dt};
		@(negedge clk_i);
		{wr_o, rd_o, data_o} = {2'b00, ~dt};
		@(negedge clk_i);
	endtask : x
endmodule : bfc_host

// ### verification/bfc_regs_sva.sv
// Port assertions for the feedback configuration registers
`timescale 1ns/1ps
module bfc_regs_sva (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire bfc_pkg::bfc_byte_t wdata_i,
	input wire logic cal_wr_i,
	input wire bfc_pkg::bfc_byte_t cal_level_i,
	input wire bfc_pkg::bfc_byte_t rdata_o,
	input wire logic actuator_type_select_o,
	input wire logic brake_enable_o
);
	import bfc_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	sequence rd19; rd_en_i && addr_i == 8'h19 && !wr_en_i && !cal_wr_i; endsequence
	sequence wr1a; wr_en_i && addr_i == 8'h1A; endsequence
	chk_calib_reset: assert property ($past(srst_i) ##0 rd19 |=> rdata_o == 8'h6F)
		else $error("calib reset");
	chk_cal_load: assert property (cal_wr_i ##1 rd19 |=> rdata_o == $past(cal_level_i, 2))
		else $error("cal load");
	chk_unmapped_rd: assert property (rd_en_i && addr_i > 8'h1A |=> rdata_o == 8'h00)
		else $error("unmapped");
	chk_type_sel: assert property (wr1a |=> actuator_type_select_o == $past(wdata_i[7]))
		else $error("type");
	chk_brake_off: assert property (wr1a |-> ##2
		brake_enable_o == ($past(wdata_i[6:4], 2) != 3'h7)) else $error("brake");
	chk_rd_hold: assert property (!rd_en_i |=> $stable(rdata_o)) else $error("hold");
endmodule : bfc_regs_sva
bind bfc_regs bfc_regs_sva u_sva (.core_clk_i, .srst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
	.cal_wr_i, .cal_level_i, .rdata_o, .actuator_type_select_o, .brake_enable_o);

// ### verification/backemf_feedback_config_test.sv
// Self-checking bench for the feedback configuration registers
`timescale 1ns/1ps
module backemf_feedback_config_test;
	logic clk = 0, rst = 1, cw = 0, wr, rd, ty, be;
	logic [7:0] a, d, lv = 0, q, v;
	logic [4:0] mu;
	logic [1:0] ag;
	logic [15:0] mv, fg;
	int fails = 0, checks_done = 0, n = 0, m[int], t[8] = '{1, 2, 3, 4, 6, 8, 16, 0};
	int gm[4] = '{255, 788, 1365, 3000};
	bfc_host H (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(a), .data_o(d));
	bfc_regs DUT (.core_clk_i(clk), .srst_i(rst), .wr_en_i(wr), .rd_en_i(rd), .addr_i(a),
		.wdata_i(d), .cal_wr_i(cw), .cal_level_i(lv), .cal_amp_gain_i(lv[1:0]), .rdata_o(q),
		.actuator_type_select_o(ty), .brake_gain_mult_o(mu), .brake_enable_o(be),
		.backemf_amp_gain_o(ag), .calib_backemf_mv_o(mv), .fb_gain_o(fg));
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (++n == 900) begin
		fails++;
		close_out();
	end
	task automatic ck(input string s, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : ck
	task automatic rc(input logic [7:0] ad);
		H.x(1'b0, ad, 8'h00);
		ck("rdata", 16'(m.exists(ad) ? m[ad] : 0), 16'(q));
	endtask : rc
	task automatic ck_ctrl;
		int c;
		c = m[26];
		ck("type_sel", 16'(c / 128), 16'(ty));
		ck("amp_gain", 16'(c % 4), 16'(ag));
		ck("mult", 16'(t[c / 16 % 8]), 16'(mu));
		ck("brake_en", 16'(c / 16 % 8 != 7), 16'(be));
	endtask : ck_ctrl
	task automatic ck_level;
		int c;
		c = m[25];
		ck("level_mv", 16'(c * 1220000 / (255 * gm[m[26] % 4])), mv);
		ck("fb_gain", 16'(c == 0 ? 65535 : 65535 / c), fg);
	endtask : ck_level
	task automatic wc(input logic [7:0] ad, dt);
		H.x(1'b1, ad, dt);
		if (ad == 8'h19 || ad == 8'h1A) begin
			m[ad] = dt;
		end
		ck_ctrl();
		ck_level();
		rc(ad);
	endtask : wc
	task automatic close_out;
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	initial begin
		void'($urandom(45805));
		m[25] = 8'h6F;
		m[26] = 8'h36;
		repeat (4) @(negedge clk);
		rst = 0;
		rc(8'h19);
		ck_ctrl();
		ck_level();
		rc(8'h1A);
		rc(8'h42);
		// mode and ratio are programmed before any calibration
		for (int c = 0; c < 8; c++) begin
			v = {c[0], c[2:0], 4'($urandom)};
			wc(8'h1A, v);
		end
		wc(8'h19, 8'($urandom));
		wc(8'h19, 8'h00);
		wc(8'h42, 8'($urandom));
		rc(8'h19);
		rc(8'h1A);
		lv = 8'($urandom);
		cw = 1;
		@(negedge clk);
		cw = 0;
		m[25] = lv;
		m[26] = (m[26] & 8'hFC) | lv[1:0];
		rc(8'h19);
		rc(8'h1A);
		ck_level();
		lv = 8'($urandom);
		cw = 1;
		fork
			H.x(1'b1, 8'h19, ~lv);
			begin
				@(negedge clk);
				cw = 0;
			end
		join
		m[25] = lv;
		m[26] = (m[26] & 8'hFC) | lv[1:0];
		rc(8'h19);
		ck_ctrl();
		ck_level();
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		m[25] = 8'h6F;
		m[26] = 8'h36;
		rc(8'h19);
		ck_ctrl();
		ck_level();
		close_out();
	end
endmodule : backemf_feedback_config_test
